/* File: eeac_core.sv */
// Extended effective address calculator with Avalon-MM register slave
// Functional notes
// - Section zero treats all addresses and displacements as 18-bit low halves.
// - With PC in section zero no reference to a nonzero section results.
// - Instruction gives 18-bit displacement, 4-bit index selector, 1-bit indirect flag.
// - Result is an 18-bit local address or 30-bit global address.
// - Local addresses take the section of the last fetched instruction or indirect word.
// - Indexing is done first, before any indirect word is fetched.
// - Index left half negative or zero: add right half, giving local address.
// - Index left half positive: add bits 6-35 to sign-extended displacement, global.
// - Indirect word is fetched from displacement plus any indexing.
// - Indirect word bit 0 one means local format, zero means global.
// - Local indirect fields in bits 13-35; bit 1 zero, bits 2-12 reserved.
// - Global indirect word indexing adds index bits 6-35 to its 30-bit address.
// - Global indexing lets carry out of bit 18 reach the section number.
// - After startup paging is off, so all references are physical.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module eeac_core #(
  parameter int NUM_XREG = eeac_pkg::NUM_XREG // Index registers
) (
  input wire logic clk,                          // 100 MHz clock
  input wire logic sys_rst,                      // Synchronous reset, active high
  input wire logic [7:0] avs_address,            // Byte address
  input wire logic avs_read,                     // Read request
  input wire logic avs_write,                    // Write request
  input wire logic [31:0] avs_writedata,         // Write data
  input wire logic [3:0] avs_byteenable,         // Byte enables
  output logic [31:0] avs_readdata,              // Read data
  output logic avs_waitrequest,                  // Stall
  output eeac_pkg::eeac_mreq_t mem_req,          // Indirect word request to memory control
  input wire eeac_pkg::eeac_mrsp_t mem_rsp,      // Memory control response
  output logic done_pulse                        // One cycle at completion
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EEAC_IDLE,
    EEAC_CALC,
    EEAC_FETCH
  } eeac_state_t;

  eeac_state_t state_reg, state_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic pager_reg, pager_next;
  logic [11:0] pc_sect_reg, pc_sect_next;
  logic [0:35] instr_reg, instr_next;
  logic [0:35] xreg_mem [NUM_XREG];
  logic done_reg, done_next;
  logic glob_reg, glob_next;
  logic rsv_err_reg, rsv_err_next;
  logic [29:0] result_reg, result_next;
  logic sect0_reg, sect0_next;
  logic [11:0] def_sect_reg, def_sect_next;
  eeac_pkg::eeac_fields_t cur_reg, cur_next;
  eeac_pkg::eeac_mreq_t mreq_reg, mreq_next;
  logic done_pulse_reg, done_pulse_next;
  logic first_reg, first_next;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc_now;
  logic wr_now;
  logic wr_ctrl;
  logic start;
  logic abort;
  logic xreg_hit;
  logic [3:0] xreg_idx;
  logic [7:0] xreg_off;
  logic xreg_hi;
  logic [31:0] wmask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  always_comb
  begin
    // The write lands on the edge where waitrequest is sampled low
    acc_now = (avs_read || avs_write) && !wait_reg;
    wr_now = avs_write && !wait_reg;
    wr_ctrl = wr_now && (avs_address == eeac_pkg::OFF_CTRL) && avs_byteenable[0];
    start = wr_ctrl && avs_writedata[eeac_pkg::CTRL_START];
    abort = wr_ctrl && avs_writedata[eeac_pkg::CTRL_ABORT];
    xreg_hit = (avs_address >= eeac_pkg::OFF_XREG_BASE) && (avs_address <= eeac_pkg::OFF_XREG_END)
               && (avs_address[1:0] == 2'b00);
    // Offset from the window base, so entry n sits at base plus 8n
    xreg_off = avs_address - eeac_pkg::OFF_XREG_BASE;
    xreg_idx = xreg_off[6:3];
    xreg_hi = !avs_address[2];
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  // ----------------------------------------------------------------
  // Datapath submodules
  // ----------------------------------------------------------------
  eeac_pkg::eeac_fields_t instr_fields;
  eeac_pkg::eeac_fields_t ind_fields;
  logic ind_rsv_err;
  logic [29:0] ea_addr;
  logic ea_glob;
  logic [0:35] xval;

  eeac_word_decode u_instr_dec (
    .word(instr_reg),
    .is_instr(1'b1),
    .sect0(sect0_reg),
    .fields(instr_fields),
    .rsv_err()
  );

  eeac_word_decode u_ind_dec (
    .word(mem_rsp.data),
    .is_instr(1'b0),
    .sect0(sect0_reg),
    .fields(ind_fields),
    .rsv_err(ind_rsv_err)
  );

  assign xval = xreg_mem[cur_reg.xsel];

  eeac_index_add u_index (
    .fields(cur_reg),
    .xval(xval),
    .sect0(sect0_reg),
    .def_sect(def_sect_reg),
    .addr(ea_addr),
    .glob(ea_glob)
  );

  // ----------------------------------------------------------------
  // Address calculation sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cur_next = cur_reg;
    def_sect_next = def_sect_reg;
    sect0_next = sect0_reg;
    mreq_next = mreq_reg;
    mreq_next.phys = !pager_reg;
    result_next = result_reg;
    glob_next = glob_reg;
    rsv_err_next = rsv_err_reg;
    done_next = done_reg;
    done_pulse_next = 1'b0;
    case (state_reg)
      EEAC_IDLE:
      begin
        if (start)
        begin
          // Instruction fields are decoded in the cycle after start
          sect0_next = (pc_sect_reg == eeac_pkg::PC_SECT_RST);
          def_sect_next = pc_sect_reg;
          done_next = 1'b0;
          rsv_err_next = 1'b0;
          state_next = EEAC_CALC;
          cur_next.glob = 1'b0;
          cur_next.ind = 1'b0;
          cur_next.xsel = 4'h0;
          cur_next.y = eeac_pkg::ADDR_RST;
        end
      end
      EEAC_CALC:
        state_next = EEAC_CALC;
      EEAC_FETCH:
      begin
        if (mem_rsp.ack)
        begin
          mreq_next.req = 1'b0;
          cur_next = ind_fields;
          rsv_err_next = rsv_err_reg || ind_rsv_err;
          if (!sect0_reg)
            def_sect_next = eeac_pkg::eeac_sect(mreq_reg.addr);
          state_next = EEAC_CALC;
        end
      end
      default:
        state_next = EEAC_IDLE;
    endcase
    // Calculation step shared by first pass and every indirect word
    if (state_reg == EEAC_CALC)
    begin
      if (first_reg)
        cur_next = instr_fields;
      else if (cur_reg.ind)
      begin
        mreq_next.req = 1'b1;
        mreq_next.addr = ea_addr;
        state_next = EEAC_FETCH;
      end
      else
      begin
        result_next = ea_addr;
        glob_next = ea_glob && !sect0_reg;
        done_next = 1'b1;
        done_pulse_next = 1'b1;
        state_next = EEAC_IDLE;
      end
    end
    // Abort frees a chain of indirect words that never ends
    if (abort)
    begin
      mreq_next.req = 1'b0;
      state_next = EEAC_IDLE;
    end
  end

  always_comb
  begin
    first_next = 1'b0;
    if (state_reg == EEAC_IDLE && start)
      first_next = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= EEAC_IDLE;
      cur_reg <= '0;
      def_sect_reg <= eeac_pkg::PC_SECT_RST;
      sect0_reg <= 1'b1;
      mreq_reg <= '0;
      result_reg <= eeac_pkg::ADDR_RST;
      glob_reg <= 1'b0;
      rsv_err_reg <= 1'b0;
      done_reg <= 1'b0;
      done_pulse_reg <= 1'b0;
      first_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      def_sect_reg <= def_sect_next;
      sect0_reg <= sect0_next;
      mreq_reg <= mreq_next;
      result_reg <= result_next;
      glob_reg <= glob_next;
      rsv_err_reg <= rsv_err_next;
      done_reg <= done_next;
      done_pulse_reg <= done_pulse_next;
      first_reg <= first_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb
  begin
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg)
      wait_next = 1'b0;
    pager_next = pager_reg;
    if (wr_ctrl)
      pager_next = avs_writedata[eeac_pkg::CTRL_PAGER];
    pc_sect_next = pc_sect_reg;
    instr_next = instr_reg;
    // Inputs are frozen while a calculation runs
    if (wr_now && state_reg == EEAC_IDLE)
    begin
      if (avs_address == eeac_pkg::OFF_PC_SECT)
        pc_sect_next = 12'(merge({20'h0_0000, pc_sect_reg}, avs_writedata, wmask));
      if (avs_address == eeac_pkg::OFF_INSTR_HI)
        instr_next[0:3] = 4'(merge({28'h000_0000, instr_reg[0:3]}, avs_writedata, wmask));
      if (avs_address == eeac_pkg::OFF_INSTR_LO)
        instr_next[4:35] = merge(instr_reg[4:35], avs_writedata, wmask);
    end
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg)
    begin
      rdata_next = eeac_pkg::DATA_ZERO;
      case (avs_address)
        eeac_pkg::OFF_CTRL: rdata_next[eeac_pkg::CTRL_PAGER] = pager_reg;
        eeac_pkg::OFF_STATUS:
        begin
          rdata_next[eeac_pkg::STS_BUSY] = (state_reg != EEAC_IDLE);
          rdata_next[eeac_pkg::STS_DONE] = done_reg;
          rdata_next[eeac_pkg::STS_GLOBAL] = glob_reg;
          rdata_next[eeac_pkg::STS_RSV_ERR] = rsv_err_reg;
          rdata_next[eeac_pkg::STS_SECT_LSB +: 12] = def_sect_reg;
        end
        eeac_pkg::OFF_PC_SECT: rdata_next[11:0] = pc_sect_reg;
        eeac_pkg::OFF_INSTR_HI: rdata_next[3:0] = instr_reg[0:3];
        eeac_pkg::OFF_INSTR_LO: rdata_next = instr_reg[4:35];
        eeac_pkg::OFF_RESULT: rdata_next[29:0] = result_reg;
        default:
        begin
          if (xreg_hit)
            rdata_next = xreg_hi ? {28'h000_0000, xreg_mem[xreg_idx][0:3]} : xreg_mem[xreg_idx][4:35];
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= eeac_pkg::DATA_ZERO;
      pager_reg <= 1'b0;
      pc_sect_reg <= eeac_pkg::PC_SECT_RST;
      instr_reg <= eeac_pkg::WORD_RST;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      pager_reg <= pager_next;
      pc_sect_reg <= pc_sect_next;
      instr_reg <= instr_next;
    end
  end

  // Index registers are plain storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (wr_now && xreg_hit && state_reg == EEAC_IDLE)
    begin
      if (xreg_hi)
        xreg_mem[xreg_idx][0:3] <= 4'(merge({28'h000_0000, xreg_mem[xreg_idx][0:3]}, avs_writedata, wmask));
      else
        xreg_mem[xreg_idx][4:35] <= merge(xreg_mem[xreg_idx][4:35], avs_writedata, wmask);
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign mem_req = mreq_reg;
  assign done_pulse = done_pulse_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sect0_stays_local: assert property (@(posedge clk) disable iff (sys_rst)
    done_pulse_reg && sect0_reg |-> !glob_reg && result_reg[29:18] == 12'h000)
    else $error("section zero produced a nonzero section");

  a_fetch_holds_req: assert property (@(posedge clk) disable iff (sys_rst)
    mreq_reg.req && !mem_rsp.ack && !abort |=> mreq_reg.req && $stable(mreq_reg.addr))
    else $error("indirect request dropped before acknowledge");

  a_ack_to_calc: assert property (@(posedge clk) disable iff (sys_rst || abort)
    state_reg == EEAC_FETCH && mem_rsp.ack |=> state_reg == EEAC_CALC && !mreq_reg.req)
    else $error("acknowledge did not resume calculation");

  a_local_default_sect: assert property (@(posedge clk) disable iff (sys_rst)
    done_pulse_reg && !glob_reg |-> result_reg[29:18] == def_sect_reg)
    else $error("local result not in default section");

  a_phys_after_reset: assert property (@(posedge clk) disable iff (sys_rst)
    mreq_reg.req && !pager_reg |-> mreq_reg.phys)
    else $error("reference not physical while pager off");

  a_wait_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    (avs_read || avs_write) && wait_reg |=> !wait_reg ##1 wait_reg)
    else $error("bus answer not after exactly one wait cycle");

  a_start_to_busy: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == EEAC_IDLE && start && !abort |=> state_reg == EEAC_CALC ##1 state_reg != EEAC_IDLE || done_pulse_reg)
    else $error("start did not begin calculation");

  a_no_ind_done: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == EEAC_CALC && !first_reg && !cur_reg.ind && !abort |=> done_pulse_reg && done_reg)
    else $error("clear indirect flag did not finish");

  a_xsel_zero_plain: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == EEAC_CALC && !first_reg && !cur_reg.ind && !cur_reg.glob && cur_reg.xsel == 4'h0 && !abort
    |=> result_reg == {$past(def_sect_reg), $past(cur_reg.y[17:0])})
    else $error("selector zero altered displacement");

endmodule : eeac_core
`default_nettype wire

/* File: eeac_pkg.sv */
// Shared constants, register map and carrier types for the effective address block
package eeac_pkg;

  // ----------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 36;
  localparam int ADDR_W = 30;
  localparam int HALF_W = 18;
  localparam int SECT_W = 12;
  localparam int XSEL_W = 4;
  localparam int NUM_XREG = 16;

  // ----------------------------------------------------------------
  // Field positions, bit 0 is the most significant bit of a word
  // ----------------------------------------------------------------
  localparam int FMT_BIT = 0;
  localparam int RSV_BIT = 1;
  localparam int GI_BIT = 1;
  localparam int GX_MSB = 2;
  localparam int GX_LSB = 5;
  localparam int GY_MSB = 6;
  localparam int LI_BIT = 13;
  localparam int LX_MSB = 14;
  localparam int LX_LSB = 17;
  localparam int LY_MSB = 18;
  localparam int WORD_LSB = 35;

  // ----------------------------------------------------------------
  // Register map, byte offsets on the Avalon-MM slave
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC_SECT = 8'h08;
  localparam logic [7:0] OFF_INSTR_HI = 8'h0C;
  localparam logic [7:0] OFF_INSTR_LO = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_XREG_BASE = 8'h40;
  localparam logic [7:0] OFF_XREG_END = 8'hBC;

  // CTRL bits
  localparam int CTRL_START = 0;
  localparam int CTRL_PAGER = 1;
  localparam int CTRL_ABORT = 2;
  // STATUS bits
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_GLOBAL = 2;
  localparam int STS_RSV_ERR = 3;
  localparam int STS_SECT_LSB = 16;

  // Reset values
  localparam logic [SECT_W-1:0] PC_SECT_RST = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 30'h0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic phys;
    logic [ADDR_W-1:0] addr;
  } eeac_mreq_t;

  typedef struct packed {
    logic ack;
    logic [0:WORD_W-1] data;
  } eeac_mrsp_t;

  // Decoded address-forming fields of an instruction or indirect word
  typedef struct packed {
    logic glob;
    logic ind;
    logic [XSEL_W-1:0] xsel;
    logic [ADDR_W-1:0] y;
  } eeac_fields_t;

  function automatic logic [SECT_W-1:0] eeac_sect(input logic [ADDR_W-1:0] a);
    eeac_sect = a[ADDR_W-1:HALF_W];
  endfunction : eeac_sect

endpackage : eeac_pkg

/* File: eeac_word_decode.sv */
// Splits an instruction or indirect word into its address-forming fields
`timescale 1ns/10ps
`default_nettype none
module eeac_word_decode (
  input wire logic [0:35] word,          // Word to decode
  input wire logic is_instr,             // Word is the instruction itself
  input wire logic sect0,                // Execution in section zero
  output eeac_pkg::eeac_fields_t fields, // Decoded fields
  output logic rsv_err                   // Local word with bit 1 set
);

  logic glob_fmt;

  always_comb
  begin
    // Instructions and all section-zero words use the local layout
    glob_fmt = !is_instr && !sect0 && !word[eeac_pkg::FMT_BIT];
    rsv_err = !is_instr && !glob_fmt && word[eeac_pkg::RSV_BIT];
    fields.glob = glob_fmt;
    if (glob_fmt)
    begin
      fields.ind = word[eeac_pkg::GI_BIT];
      fields.xsel = word[eeac_pkg::GX_MSB:eeac_pkg::GX_LSB];
      fields.y = word[eeac_pkg::GY_MSB:eeac_pkg::WORD_LSB];
    end
    else
    begin
      fields.ind = word[eeac_pkg::LI_BIT];
      fields.xsel = word[eeac_pkg::LX_MSB:eeac_pkg::LX_LSB];
      fields.y = {12'h000, word[eeac_pkg::LY_MSB:eeac_pkg::WORD_LSB]};
    end
  end

endmodule : eeac_word_decode
`default_nettype wire

/* File: eeac_index_add.sv */
// Indexing adder: forms a local or global address from Y, X and the default section
`timescale 1ns/10ps
`default_nettype none
module eeac_index_add (
  input wire eeac_pkg::eeac_fields_t fields, // Current Y, X, format
  input wire logic [0:35] xval,              // Contents of selected index register
  input wire logic sect0,                    // Execution in section zero
  input wire logic [11:0] def_sect,          // Default section
  output logic [29:0] addr,                  // Resulting address
  output logic glob                          // Result is a global address
);

  logic [17:0] lsum;
  logic [29:0] ysext;
  logic lh_pos;

  always_comb
  begin
    lsum = fields.y[17:0] + xval[eeac_pkg::LY_MSB:eeac_pkg::WORD_LSB];
    ysext = {{12{fields.y[17]}}, fields.y[17:0]};
    lh_pos = !xval[0] && (xval[0:17] != 18'h0_0000);
    addr = {def_sect, fields.y[17:0]};
    glob = 1'b0;
    if (fields.glob)
    begin
      glob = 1'b1;
      addr = fields.y;
      if (fields.xsel != 4'h0)
        addr = fields.y + xval[eeac_pkg::GY_MSB:eeac_pkg::WORD_LSB];
    end
    else if (fields.xsel == 4'h0)
      addr = {def_sect, fields.y[17:0]};
    else if (sect0 || !lh_pos)
      addr = {def_sect, lsum};
    else
    begin
      glob = 1'b1;
      addr = ysext + xval[eeac_pkg::GY_MSB:eeac_pkg::WORD_LSB];
    end
  end

endmodule : eeac_index_add
`default_nettype wire

/* File: eeac_mcu_model.sv */
// Memory control model answering indirect word fetches
`timescale 1ns/10ps
`default_nettype none
module eeac_mcu_model (
  input wire logic clk,                      // Clock
  input wire logic rst,                      // Synchronous reset, active high
  input wire eeac_pkg::eeac_mreq_t mem_req,  // Request from the block
  input wire logic slow,                     // Stretch the answer
  output eeac_pkg::eeac_mrsp_t mem_rsp,      // Answer to the block
  output logic virt_seen                     // A request came with pager on
);
  logic [35:0] mem [logic [29:0]];
  int wait_cnt = 0;
  logic spent = 1'b0;
  // ----------------------------------------------------------------
  // One answer per request, data toggles when not valid
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    mem_rsp.ack <= 1'b0;
    mem_rsp.data <= ~mem_rsp.data;
    if (rst)
    begin
      mem_rsp.data <= '0;
      virt_seen <= 1'b0;
      spent <= 1'b0;
      wait_cnt <= 0;
    end
    else if (!mem_req.req)
    begin
      spent <= 1'b0;
      wait_cnt <= 0;
    end
    else if (!spent)
    begin
      if (!mem_req.phys) virt_seen <= 1'b1;
      if (wait_cnt >= (slow ? 5 : 0))
      begin
        mem_rsp.ack <= 1'b1;
        mem_rsp.data <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 36'hA_5A5A_5A5A;
        spent <= 1'b1;
      end
      else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : eeac_mcu_model
`default_nettype wire

/* File: extended_effective_address_calc_bench.sv */
// Self-checking bench for the effective address block
`timescale 1ns/10ps
`default_nettype none
module extended_effective_address_calc_bench;
  typedef struct {logic [11:0] sect; logic [35:0] ins; logic [29:0] ea; logic glob; logic [11:0] dsect;
    logic rsv;} eeac_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic done_pulse;
  logic slow = 1'b0;
  logic virt_seen;
  eeac_pkg::eeac_mreq_t mem_req;
  eeac_pkg::eeac_mrsp_t mem_rsp;
  int n_errors = 0;
  int checks_done = 0;
  int n_done = 0;
  eeac_row_t rows [9];
  logic [31:0] q;

  always #5 clk = ~clk;

  // Completion pulses, one per finished calculation
  always @(posedge clk)
    if (done_pulse === 1'b1) n_done <= n_done + 1;

  eeac_core #(.NUM_XREG(16)) uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .done_pulse(done_pulse));
  eeac_mcu_model mcu (.clk(clk), .rst(sys_rst), .mem_req(mem_req), .slow(slow), .mem_rsp(mem_rsp),
    .virt_seen(virt_seen));

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr36(input logic [7:0] a, input logic [35:0] w);
    logic [31:0] r;
    bus(1'b0, a, {28'h000_0000, w[35:32]}, r);
    bus(1'b0, a + 8'h04, w[31:0], r);
  endtask : wr36

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [35:0] ins(input logic i, input logic [3:0] x, input logic [17:0] y);
    ins = {13'h0000, i, x, y};
  endfunction : ins

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Hang guard, well beyond the longest expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mcu.mem[{12'h005, 18'h0_0300}] = 36'h1_00C0_1000;
    mcu.mem[{12'h007, 18'h0_0400}] = 36'h8_0040_0500;
    mcu.mem[{12'h007, 18'h0_0500}] = 36'h0_0048_0034;
    mcu.mem[{12'h002, 18'h0_0040}] = 36'h4_0024_0010;
    mcu.mem[{12'h009, 18'h0_0010}] = 36'h8_0000_0020;
    mcu.mem[{12'h003, 18'h0_0060}] = 36'hC_0000_0070;
    rows = '{
      '{12'h003, ins(0, 0, 18'h0_0400), {12'h003, 18'h0_0400}, 0, 12'h003, 0},
      '{12'h022, ins(0, 1, 18'h0_1000), {12'h022, 18'h0_1100}, 0, 12'h022, 0},
      '{12'h005, ins(0, 2, 18'h0_0002), {12'h005, 18'h0_0001}, 0, 12'h005, 0},
      '{12'h011, ins(0, 3, 18'h3_FF00), {12'h021, 18'h3_FF80}, 1, 12'h011, 0},
      '{12'h000, ins(0, 3, 18'h3_FF00), {12'h000, 18'h3_FF80}, 0, 12'h000, 0},
      '{12'h005, ins(1, 1, 18'h0_0200), {12'h030, 18'h0_1100}, 1, 12'h005, 0},
      '{12'h007, ins(1, 0, 18'h0_0400), {12'h012, 18'h0_0034}, 1, 12'h007, 0},
      '{12'h002, ins(1, 0, 18'h0_0040), {12'h009, 18'h0_0020}, 0, 12'h009, 0},
      '{12'h003, ins(1, 0, 18'h0_0060), {12'h003, 18'h0_0070}, 0, 12'h003, 1}};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, eeac_pkg::OFF_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, eeac_pkg::OFF_PC_SECT, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    // Unmapped place: write dropped, read gives zero
    bus(1'b0, 8'h20, 32'hFFFF_FFFF, q);
    bus(1'b1, 8'h20, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    wr36(8'h48, 36'h0_0000_0100);
    wr36(8'h50, 36'hF_FFFF_FFFF);
    wr36(8'h58, 36'h0_0088_0080);
    wr36(8'h60, 36'h0_0000_0100);
    foreach (rows[i])
    begin
      slow <= i[0];
      bus(1'b0, eeac_pkg::OFF_PC_SECT, {20'h0_0000, rows[i].sect}, q);
      wr36(eeac_pkg::OFF_INSTR_HI, rows[i].ins);
      bus(1'b0, eeac_pkg::OFF_CTRL, 32'h0000_0001, q);
      for (int k = 0; k < 60; k++)
      begin
        bus(1'b1, eeac_pkg::OFF_STATUS, 32'h0000_0000, q);
        if (q[1] === 1'b1) break;
      end
      chk(q, {4'h0, rows[i].dsect, 12'h000, rows[i].rsv, rows[i].glob, 2'b10});
      bus(1'b1, eeac_pkg::OFF_RESULT, 32'h0000_0000, q);
      chk(q, {2'b00, rows[i].ea});
    end
    chk({31'h0000_0000, virt_seen}, 32'h0000_0000);
    chk(n_done, 32'h0000_0009);
    // Endless indirect chain, only abort frees it
    mcu.mem[{12'h006, 18'h0_0700}] = 36'h8_0040_0700;
    bus(1'b0, eeac_pkg::OFF_PC_SECT, 32'h0000_0006, q);
    wr36(eeac_pkg::OFF_INSTR_HI, ins(1, 0, 18'h0_0700));
    bus(1'b0, eeac_pkg::OFF_CTRL, 32'h0000_0001, q);
    bus(1'b1, eeac_pkg::OFF_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0006_0001);
    bus(1'b0, eeac_pkg::OFF_CTRL, 32'h0000_0004, q);
    bus(1'b1, eeac_pkg::OFF_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0006_0000);
    // Pager on, then a reset in mid-run must turn it off again
    bus(1'b0, eeac_pkg::OFF_CTRL, 32'h0000_0002, q);
    bus(1'b1, eeac_pkg::OFF_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0002);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b1, eeac_pkg::OFF_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, eeac_pkg::OFF_PC_SECT, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    end_sim;
  end
endmodule : extended_effective_address_calc_bench
`default_nettype wire
